// File: design/emsw_regs.vh
// Register map, field positions, reset values and timing for the external memory strobe and wait controller.
//
// Notes on behaviour
// - Toggle bit clear: interface pins stay static except on real external accesses.
// - Toggle bit set, protection off: pins toggle on internal accesses, primary data strobe excepted.
// - Drive bit selects low-noise buffers at 0, high-drive on the named port pins at 1.
// - Segment save off: entry pushes PC and flags only; interrupt segment replaces code segment.
// - Segment save on: entry also pushes code segment, loads it from interrupt segment; return restores.
// - Remap bit swaps the four data page registers with port 0 to 3 data registers.
// - Lower address strobe stretch adds 0 to 3 cycles when address bit 21 is 0; reset 3.
// - Upper address strobe stretch adds 0 to 3 cycles when address bit 21 is 1; reset 3.
// - Top bit of the wait register is held at 0 and reads 0.
// - Clearing the watchdog enable bit puts the timer into watchdog mode.
// - Upper data strobe stretch adds 0 to 7 internal clock cycles; reset 7.
// - Lower data strobe stretch adds 0 to 7 internal clock cycles; reset 7.
// - Stretch cycles count internal clock periods, not processor clock periods.
// - Address bit 21 splits space into lower and upper 2 Mbyte blocks, separate settings.
// - Enabled wait input sampled low in T1 or T2 once the stretch count is spent adds a cycle, resampled each cycle.
// - Second strobe enabled: lower block uses second strobe, primary high; upper holds second high.
// - Address strobe is low during T1; its rising edge marks address and direction valid.
`ifndef EMSW_REGS_VH
`define EMSW_REGS_VH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define EMSW_IDX_MODE 8'hF5
`define EMSW_IDX_STRETCH 8'hF6
`define EMSW_IDX_WAIT 8'hFC

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define EMSW_RST_MODE 8'h80
`define EMSW_MASK_MODE 8'h76
`define EMSW_RST_STRETCH 8'h1F
`define EMSW_MASK_STRETCH 8'h7F
`define EMSW_RST_WAIT 8'h7F
`define EMSW_MASK_WAIT 8'h7F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EMSW_MODE_FORMAT 6
`define EMSW_MODE_SECOND_STROBE_ENABLE 5
`define EMSW_MODE_ASAF 4
`define EMSW_MODE_TOGGLE 2
`define EMSW_MODE_DRIVE 1
`define EMSW_STR_SEGSAVE 6
`define EMSW_STR_REMAP 5
`define EMSW_STR_MEMORY_SELECT_BIT 4
`define EMSW_STR_LAS_HI 3
`define EMSW_STR_LAS_LO 2
`define EMSW_STR_UAS_HI 1
`define EMSW_STR_UAS_LO 0
`define EMSW_WAIT_WDG 6
`define EMSW_WAIT_UDS_HI 5
`define EMSW_WAIT_UDS_LO 3
`define EMSW_WAIT_LDS_HI 2
`define EMSW_WAIT_LDS_LO 0
`define EMSW_BLOCK_BIT 21

`endif

// File: design/emsw_ctrl.v
// External memory strobe, stretch and mode controller with APB register access.
`timescale 1ns/1ps
`include "emsw_regs.vh"

module emsw_ctrl #(
	parameter ADDR_W = 22,
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Processor memory request
	input wire mem_req,
	input wire mem_external,
	input wire mem_we,
	input wire [ADDR_W-1:0] mem_addr,
	input wire [DATA_W-1:0] mem_wdata,
	input wire mem_protect_off,
	output reg mem_busy,
	output reg mem_done,
	output reg [DATA_W-1:0] mem_rdata,
	// External memory pins
	output reg address_strobe_n,
	output reg data_strobe_n,
	output reg second_data_strobe_n,
	output reg rw_n,
	output reg [ADDR_W-9:0] addr_high,
	output reg [DATA_W-1:0] ad_out,
	output reg ad_oe,
	input wire [DATA_W-1:0] ad_in,
	input wire wait_n,
	input wire wait_enable,
	// Interrupt stack frame control
	input wire irq_entry,
	input wire irq_return,
	output reg push_code_segment,
	output reg load_code_segment,
	output reg pop_code_segment,
	output reg isr_overrides_csr,
	// Configuration outputs
	output reg strobe_format_mode,
	output reg as_alt_function,
	output reg [1:0] high_drive_p4,
	output reg [1:0] high_drive_p6,
	output reg page_reg_remap,
	output reg memory_select_bit,
	output reg watchdog_mode
);

	// ----------------------------------------
	// States of the memory cycle
	// ----------------------------------------
	localparam S_IDLE = 3'd0;
	localparam S_T1 = 3'd1;
	localparam S_T2 = 3'd2;
	localparam S_INT1 = 3'd3;
	localparam S_INT2 = 3'd4;

	reg [7:0] ext_mem_mode_ctrl;
	reg [7:0] ext_mem_strobe_stretch_ctrl;
	reg [7:0] wait_cycle_ctrl;
	reg [2:0] state;
	reg [2:0] stretch_cnt;
	reg cyc_upper;
	reg cyc_we;
	reg [DATA_W-1:0] cyc_wdata;

	wire [9:0] word_index;
	wire hit_mode;
	wire hit_stretch;
	wire hit_wait;
	wire apb_write;
	wire internal_toggle_enable;
	wire second_strobe_enable;
	wire [1:0] lower_addr_strobe_stretch;
	wire [1:0] upper_addr_strobe_stretch;
	wire [2:0] upper_data_stretch;
	wire [2:0] lower_data_stretch;
	wire req_upper;
	wire wait_active;
	wire phase_end;
	reg [7:0] read_value;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	assign word_index = paddr[11:2];
	assign hit_mode = (word_index == {2'b00, `EMSW_IDX_MODE});
	assign hit_stretch = (word_index == {2'b00, `EMSW_IDX_STRETCH});
	assign hit_wait = (word_index == {2'b00, `EMSW_IDX_WAIT});
	assign apb_write = psel & penable & pready & pwrite;

	assign internal_toggle_enable = ext_mem_mode_ctrl[`EMSW_MODE_TOGGLE];
	assign second_strobe_enable = ext_mem_mode_ctrl[`EMSW_MODE_SECOND_STROBE_ENABLE];
	assign lower_addr_strobe_stretch = ext_mem_strobe_stretch_ctrl[`EMSW_STR_LAS_HI:`EMSW_STR_LAS_LO];
	assign upper_addr_strobe_stretch = ext_mem_strobe_stretch_ctrl[`EMSW_STR_UAS_HI:`EMSW_STR_UAS_LO];
	assign upper_data_stretch = wait_cycle_ctrl[`EMSW_WAIT_UDS_HI:`EMSW_WAIT_UDS_LO];
	assign lower_data_stretch = wait_cycle_ctrl[`EMSW_WAIT_LDS_HI:`EMSW_WAIT_LDS_LO];
	assign req_upper = mem_addr[`EMSW_BLOCK_BIT];
	assign wait_active = wait_enable & ~wait_n;
	// A phase ends only once the programmed count is spent and the wait input is released or not enabled.
	assign phase_end = (stretch_cnt == 3'h0) & ~wait_active;

	always @* begin
		read_value = 8'h00;
		if (hit_mode) begin
			read_value = ext_mem_mode_ctrl;
		end else if (hit_stretch) begin
			read_value = ext_mem_strobe_stretch_ctrl & `EMSW_MASK_STRETCH;
		end else if (hit_wait) begin
			read_value = wait_cycle_ctrl & `EMSW_MASK_WAIT;
		end
	end

	// ----------------------------------------
	// APB slave, no wait states; pready is raised from the setup phase
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			ext_mem_mode_ctrl <= `EMSW_RST_MODE;
			ext_mem_strobe_stretch_ctrl <= `EMSW_RST_STRETCH;
			wait_cycle_ctrl <= `EMSW_RST_WAIT;
		end else begin
			if (psel & ~penable) begin
				pready <= 1'b1;
				pslverr <= ~(hit_mode | hit_stretch | hit_wait);
				prdata <= {24'h000000, read_value};
			end else if (psel & penable & pready) begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
			if (apb_write & hit_mode) begin
				// Bit 7 keeps its reset value; the other reserved bits stay clear.
				ext_mem_mode_ctrl <= (pwdata[7:0] & `EMSW_MASK_MODE) | (`EMSW_RST_MODE & ~`EMSW_MASK_MODE);
			end
			if (apb_write & hit_stretch) begin
				ext_mem_strobe_stretch_ctrl <= pwdata[7:0] & `EMSW_MASK_STRETCH;
			end
			if (apb_write & hit_wait) begin
				wait_cycle_ctrl <= pwdata[7:0] & `EMSW_MASK_WAIT;
			end
		end
	end

	// ----------------------------------------
	// Configuration outputs
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strobe_format_mode <= 1'b0;
			as_alt_function <= 1'b0;
			high_drive_p4 <= 2'h0;
			high_drive_p6 <= 2'h0;
			page_reg_remap <= 1'b0;
			memory_select_bit <= 1'b1;
			watchdog_mode <= 1'b0;
		end else begin
			strobe_format_mode <= ext_mem_mode_ctrl[`EMSW_MODE_FORMAT];
			as_alt_function <= ext_mem_mode_ctrl[`EMSW_MODE_ASAF];
			high_drive_p4 <= {2{ext_mem_mode_ctrl[`EMSW_MODE_DRIVE]}};
			high_drive_p6 <= {2{ext_mem_mode_ctrl[`EMSW_MODE_DRIVE]}};
			page_reg_remap <= ext_mem_strobe_stretch_ctrl[`EMSW_STR_REMAP];
			memory_select_bit <= ext_mem_strobe_stretch_ctrl[`EMSW_STR_MEMORY_SELECT_BIT];
			watchdog_mode <= ~wait_cycle_ctrl[`EMSW_WAIT_WDG];
		end
	end

	// ----------------------------------------
	// Interrupt stack frame control
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			push_code_segment <= 1'b0;
			load_code_segment <= 1'b0;
			pop_code_segment <= 1'b0;
			isr_overrides_csr <= 1'b0;
		end else begin
			push_code_segment <= irq_entry & ext_mem_strobe_stretch_ctrl[`EMSW_STR_SEGSAVE];
			load_code_segment <= irq_entry & ext_mem_strobe_stretch_ctrl[`EMSW_STR_SEGSAVE];
			pop_code_segment <= irq_return & ext_mem_strobe_stretch_ctrl[`EMSW_STR_SEGSAVE];
			// The override lasts from entry to return, so the routine stays in one 64K segment.
			if (irq_entry & ~ext_mem_strobe_stretch_ctrl[`EMSW_STR_SEGSAVE]) begin
				isr_overrides_csr <= 1'b1;
			end else if (irq_return) begin
				isr_overrides_csr <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Memory cycle sequencer
	// ----------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			stretch_cnt <= 3'h0;
			cyc_upper <= 1'b0;
			cyc_we <= 1'b0;
			cyc_wdata <= {DATA_W{1'b0}};
			mem_busy <= 1'b0;
			mem_done <= 1'b0;
			mem_rdata <= {DATA_W{1'b0}};
			address_strobe_n <= 1'b1;
			data_strobe_n <= 1'b1;
			second_data_strobe_n <= 1'b1;
			rw_n <= 1'b1;
			addr_high <= {(ADDR_W-8){1'b0}};
			ad_out <= {DATA_W{1'b0}};
			ad_oe <= 1'b0;
		end else begin
			mem_done <= 1'b0;
			case (state)
				S_IDLE: begin
					if (mem_req) begin
						cyc_upper <= req_upper;
						cyc_we <= mem_we;
						cyc_wdata <= mem_wdata;
						if (mem_external | (internal_toggle_enable & mem_protect_off)) begin
							mem_busy <= 1'b1;
							address_strobe_n <= 1'b0;
							rw_n <= ~mem_we;
							addr_high <= mem_addr[ADDR_W-1:8];
							ad_out <= mem_addr[7:0];
							ad_oe <= 1'b1;
							if (mem_external) begin
								state <= S_T1;
								stretch_cnt <= {1'b0, req_upper ? upper_addr_strobe_stretch :
									lower_addr_strobe_stretch};
							end else begin
								state <= S_INT1;
							end
						end else begin
							// Internal access with toggling off or protection on leaves every pin where it was.
							mem_done <= 1'b1;
						end
					end
				end
				S_T1: begin
					if (!phase_end) begin
						if (stretch_cnt != 3'h0) begin
							stretch_cnt <= stretch_cnt - 3'h1;
						end
					end else begin
						state <= S_T2;
						address_strobe_n <= 1'b1;
						ad_out <= cyc_wdata;
						ad_oe <= cyc_we;
						stretch_cnt <= cyc_upper ? upper_data_stretch : lower_data_stretch;
						if (second_strobe_enable & ~cyc_upper) begin
							second_data_strobe_n <= 1'b0;
						end else begin
							data_strobe_n <= 1'b0;
						end
					end
				end
				S_T2: begin
					if (!phase_end) begin
						if (stretch_cnt != 3'h0) begin
							stretch_cnt <= stretch_cnt - 3'h1;
						end
					end else begin
						state <= S_IDLE;
						data_strobe_n <= 1'b1;
						second_data_strobe_n <= 1'b1;
						ad_oe <= 1'b0;
						mem_rdata <= ad_in;
						mem_done <= 1'b1;
						mem_busy <= 1'b0;
					end
				end
				S_INT1: begin
					state <= S_INT2;
					address_strobe_n <= 1'b1;
					ad_out <= cyc_wdata;
					ad_oe <= cyc_we;
					// The primary data strobe never toggles on an internal access.
					if (second_strobe_enable & ~cyc_upper) begin
						second_data_strobe_n <= 1'b0;
					end
				end
				S_INT2: begin
					state <= S_IDLE;
					second_data_strobe_n <= 1'b1;
					ad_oe <= 1'b0;
					mem_done <= 1'b1;
					mem_busy <= 1'b0;
				end
				default: begin
					state <= S_IDLE;
					mem_busy <= 1'b0;
				end
			endcase
		end
	end

endmodule // emsw_ctrl

// File: testbench/emsw_checker.sv
// Concurrent checks on the ports of the strobe and wait controller.
`timescale 1ns/1ps
module emsw_checker (
	// Clock, reset and bus answer
	input wire clock,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pready,
	// Memory cycle
	input wire mem_external,
	input wire mem_busy,
	input wire mem_done,
	input wire address_strobe_n,
	input wire data_strobe_n,
	input wire second_data_strobe_n,
	// Interrupt frame
	input wire irq_entry,
	input wire irq_return,
	input wire push_code_segment,
	input wire pop_code_segment,
	input wire isr_overrides_csr
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	idle_static_a: assert property (!mem_busy && !mem_done |-> address_strobe_n && data_strobe_n && second_data_strobe_n)
		else $error("strobe active with no cycle running");
	as_alone_a: assert property (!address_strobe_n |-> data_strobe_n && second_data_strobe_n)
		else $error("address and data strobe overlap");
	one_strobe_a: assert property (!second_data_strobe_n |-> data_strobe_n)
		else $error("both data strobes active");
	as_then_ds_a: assert property (mem_external && $rose(address_strobe_n) |-> !data_strobe_n || !second_data_strobe_n)
		else $error("no data strobe after address strobe");
	done_pulse_a: assert property (mem_done |=> !mem_done)
		else $error("done held longer than one cycle");
	push_cause_a: assert property (push_code_segment |-> $past(irq_entry))
		else $error("code segment push without entry");
	pop_cause_a: assert property (pop_code_segment |-> $past(irq_return))
		else $error("code segment pop without return");
	isr_override_a: assert property ($rose(isr_overrides_csr) |-> $past(irq_entry))
		else $error("segment override without entry");
endmodule // emsw_checker

bind emsw_ctrl emsw_checker chk_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.mem_external(mem_external), .mem_busy(mem_busy), .mem_done(mem_done), .address_strobe_n(address_strobe_n),
	.data_strobe_n(data_strobe_n), .second_data_strobe_n(second_data_strobe_n), .irq_entry(irq_entry),
	.irq_return(irq_return), .push_code_segment(push_code_segment), .pop_code_segment(pop_code_segment),
	.isr_overrides_csr(isr_overrides_csr));

// File: testbench/emsw_mem.sv
// External memory model answering reads on the multiplexed bus.
`timescale 1ns/1ps
module emsw_mem (
	// Pins from the controller
	input wire clock,
	input wire address_strobe_n,
	input wire data_strobe_n,
	input wire second_data_strobe_n,
	input wire [7:0] ad_out,
	// Read data back
	output wire [7:0] ad_in
);
	// ----------------------------------------
	// Behaviour
	// ----------------------------------------
	reg [7:0] latch_addr = 8'h00;
	reg [7:0] churn = 8'h00;
	// An unselected bus moves every cycle, so a capture outside the strobe cannot match by luck.
	assign ad_in = (!data_strobe_n || !second_data_strobe_n) ? latch_addr ^ 8'h5A : churn;
	always @(posedge clock) begin
		churn <= churn + 8'h3B;
		if (!address_strobe_n)
			latch_addr <= ad_out;
	end
endmodule // emsw_mem

// File: testbench/emsw_ctrl_tb.sv
// Self-checking bench for the strobe and wait controller.
`timescale 1ns/1ps
`include "emsw_regs.vh"
module emsw_ctrl_tb;
	// ----------------------------------------
	// Signals, instances and tasks
	// ----------------------------------------
	localparam [11:0] a_mode = `EMSW_IDX_MODE * 4;
	localparam [11:0] a_str = `EMSW_IDX_STRETCH * 4;
	localparam [11:0] a_wait = `EMSW_IDX_WAIT * 4;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic mem_req, mem_external, mem_we, mem_protect_off, mem_busy, mem_done, wait_n, wait_enable;
	logic [21:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata, ad_out, ad_in;
	logic as_n, ds_n, ds2_n, rw_n, ad_oe, irq_entry, irq_return, push, load, pop, ovr;
	logic fmt, asaf, remap, msel, wdm, s_push, s_load, s_pop;
	logic [1:0] hd4, hd6;
	logic [13:0] ah;
	logic [3:0] lo;
	int n_errors = 0, check_count = 0, n;
	emsw_ctrl dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
		.mem_external(mem_external), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_protect_off(mem_protect_off), .mem_busy(mem_busy), .mem_done(mem_done), .mem_rdata(mem_rdata),
		.address_strobe_n(as_n), .data_strobe_n(ds_n), .second_data_strobe_n(ds2_n), .rw_n(rw_n), .addr_high(ah),
		.ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .wait_n(wait_n), .wait_enable(wait_enable),
		.irq_entry(irq_entry), .irq_return(irq_return), .push_code_segment(push), .load_code_segment(load),
		.pop_code_segment(pop), .isr_overrides_csr(ovr), .strobe_format_mode(fmt), .as_alt_function(asaf),
		.high_drive_p4(hd4), .high_drive_p6(hd6), .page_reg_remap(remap), .memory_select_bit(msel),
		.watchdog_mode(wdm));
	emsw_mem mem_u (.clock(clock), .address_strobe_n(as_n), .data_strobe_n(ds_n), .second_data_strobe_n(ds2_n),
		.ad_out(ad_out), .ad_in(ad_in));
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", check_count, n_errors);
			if (n_errors == 0 && check_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			check_count++;
			if (got !== exp) begin
				n_errors++;
				$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [7:0] d);
		int k;
		begin
			k = 0;
			@(posedge clock);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h0, d};
			@(posedge clock);
			penable <= 1;
			do begin
				@(posedge clock);
				k++;
			end while (pready !== 1'b1 && k < 50);
			if (pready !== 1'b1) begin
				n_errors++;
				$display("MISMATCH apb pready expected 1 seen %b", pready);
			end
			r = prdata;
			e = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task rdc(input string nm, input [11:0] a, input [7:0] ex);
		begin
			apb(0, a, 8'h00);
			chk(nm, {24'h0, ex}, r);
		end
	endtask
	// Request is dropped right after the take edge, so the edge after done cannot start a second cycle.
	task mem(input x, input w, input [21:0] a, input int wl);
		begin
			@(posedge clock);
			mem_external <= x;
			mem_we <= w;
			mem_addr <= a;
			mem_wdata <= ~a[7:0];
			wait_n <= (wl == 0);
			mem_req <= 1;
			lo = 4'h0;
			n = 0;
			@(posedge clock);
			mem_req <= 0;
			do begin
				@(posedge clock);
				n++;
				lo = lo | {~as_n, ~ds_n, ~ds2_n, ~rw_n};
				if (n == wl)
					wait_n <= 1;
			end while (mem_done !== 1'b1 && n < 100);
			if (mem_done !== 1'b1) begin
				n_errors++;
				$display("MISMATCH mem_done expected 1 seen %b", mem_done);
			end
		end
	endtask
	task irq(input en);
		begin
			@(posedge clock);
			irq_entry <= en;
			irq_return <= !en;
			@(posedge clock);
			irq_entry <= 0;
			irq_return <= 0;
			{s_push, s_load, s_pop} = 3'b000;
			repeat (3) begin
				@(posedge clock);
				{s_push, s_load, s_pop} = {s_push | push, s_load | load, s_pop | pop};
			end
		end
	endtask
	task t_regs;
		begin
			rdc("mode reset", a_mode, 8'h80);
			rdc("stretch reset", a_str, 8'h1F);
			rdc("wait reset", a_wait, 8'h7F);
			apb(0, 12'h000, 8'h00);
			chk("unmapped error", 1, e);
			apb(1, a_mode, 8'hFF);
			apb(1, a_str, 8'hFF);
			apb(1, a_wait, 8'hFF);
			rdc("mode readback", a_mode, 8'hF6);
			rdc("stretch readback", a_str, 8'h7F);
			rdc("wait readback", a_wait, 8'h7F);
			chk("high drive", 4'hF, {hd4, hd6});
			chk("config bits", 5'b11011, {fmt, asaf, wdm, msel, remap});
			apb(1, a_mode, 8'h00);
			apb(1, a_wait, 8'h3F);
			apb(1, a_str, 8'h10);
			repeat (2) @(negedge clock);
			chk("low drive", 5'h00, {hd4, hd6, remap});
			chk("watchdog mode", 1, wdm);
			$display("test regs done");
		end
	endtask
	task t_seg;
		begin
			apb(1, a_str, 8'h50);
			irq(1);
			chk("save entry", 3'b110, {s_push, s_load, ovr});
			irq(0);
			chk("save return", 1, s_pop);
			apb(1, a_str, 8'h10);
			irq(1);
			chk("plain entry", 3'b001, {s_push, s_load, ovr});
			irq(0);
			chk("plain return", 2'b00, {s_pop, ovr});
			$display("test segment done");
		end
	endtask
	task t_stretch;
		int i;
		logic [2:0] ld;
		begin
			for (i = 0; i < 4; i++) begin
				ld = (i * 5) % 8;
				apb(1, a_str, {4'h1, i[1:0], 2'd3 - i[1:0]});
				apb(1, a_wait, {2'b01, 3'd7 - ld, ld});
				mem(1, 0, 22'h0000A0 + i, 0);
				chk("lower cycles", 3 + i + ld, n);
				chk("lower data", {24'h0, mem_addr[7:0] ^ 8'h5A}, mem_rdata);
				mem(1, 0, 22'h2000B0 + i, 0);
				chk("upper cycles", 3 + (3 - i) + (7 - ld), n);
				chk("upper address", 14'h2000, ah);
			end
			$display("test stretch done");
		end
	endtask
	task t_strobes;
		begin
			apb(1, a_wait, 8'h40);
			mem(1, 0, 22'h000011, 0);
			chk("lower primary", 4'b1100, lo);
			apb(1, a_mode, 8'h20);
			mem(1, 0, 22'h000012, 0);
			chk("lower second", 4'b1010, lo);
			mem(1, 0, 22'h200013, 0);
			chk("upper primary", 4'b1100, lo);
			mem(0, 0, 22'h000014, 0);
			chk("internal static", 4'b0000, lo);
			chk("internal cycles", 1, n);
			apb(1, a_mode, 8'h24);
			mem(0, 0, 22'h000015, 0);
			chk("protected static", 4'b0000, lo);
			mem_protect_off <= 1;
			mem(0, 0, 22'h200016, 0);
			chk("toggle upper", 4'b1000, lo);
			mem(0, 0, 22'h000017, 0);
			chk("toggle lower", 4'b1010, lo);
			mem_protect_off <= 0;
			apb(1, a_mode, 8'h00);
			mem(1, 1, 22'h000018, 0);
			chk("write strobes", 4'b1101, lo);
			chk("bus released", 0, ad_oe);
			$display("test strobes done");
		end
	endtask
	task t_wait;
		begin
			apb(1, a_str, 8'h10);
			wait_enable <= 0;
			mem(1, 0, 22'h000020, 3);
			chk("wait ignored", 3, n);
			wait_enable <= 1;
			mem(1, 0, 22'h000021, 3);
			chk("wait stretch", 6, n);
			$display("test wait done");
		end
	endtask
	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	initial begin
		#1000000;
		n_errors++;
		print_verdict;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, mem_req, mem_external, mem_we} = 0;
		{mem_addr, mem_wdata, mem_protect_off, wait_enable, irq_entry, irq_return} = 0;
		wait_n = 1;
		rst_n = 0;
		repeat (3) @(posedge clock);
		rst_n <= 1;
		t_regs;
		t_seg;
		t_stretch;
		t_strobes;
		t_wait;
		print_verdict;
	end
endmodule // emsw_ctrl_tb
